// >>> core/adcrc_pkg.sv
package adcrc_pkg;
    localparam int CLK_NS          = 20;
    localparam int CONV_NS         = 4000;
    localparam int CONV_CYC        = (CONV_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOST_STROBE_CYC = 2;
    localparam int NCH             = 8;
    localparam int WBITS           = 16;
    localparam logic [2:0] RATIO_WIDE = 3'h7;
    // host register word addresses
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_CFG  = 4'h1;
    localparam logic [3:0] REG_STAT = 4'h2;
    localparam logic [3:0] REG_DATA = 4'h8;
    // control bits
    localparam int CTRL_SA = 0;
    localparam int CTRL_SB = 1;
    localparam int CTRL_RD = 2;
    // configuration bits
    localparam int CFG_IFS = 0;
    localparam int CFG_BYS = 1;
    localparam int CFG_ORD = 2;
    localparam int CFG_RATIO = 3;
    localparam int CFG_SBY = 6;
    localparam int CFG_RNG = 7;
    localparam int CFG_SPL = 8;
    localparam logic [8:0] CFG_RST = 9'h0c0;
    // status bits
    localparam int STAT_BUSY  = 0;
    localparam int STAT_FRAME = 1;
    localparam int STAT_FERR  = 2;
    localparam int STAT_FLAG  = 3;
    localparam int STAT_PULSE = 4;

    typedef enum logic [1:0] {ADCRC_PAR, ADCRC_BYTE, ADCRC_SER} adcrc_mode_t;

    // the unused combination falls back to parallel
    function automatic adcrc_mode_t adcrc_mode_f(input logic ifs, input logic bys);
        if (!ifs)
            return ADCRC_PAR;
        return bys ? ADCRC_BYTE : ADCRC_SER;
    endfunction

    function automatic logic [2:0] adcrc_ratio_shift_f(input logic [2:0] code);
        return (code == RATIO_WIDE) ? 3'h0 : code;
    endfunction
endpackage

// >>> core/adcrc_if.sv
`timescale 1ns/1ns
interface adcrc_if;
    logic        cs_n;
    logic        rd_sclk;
    logic        convert_start_group_a;
    logic        convert_start_group_b;
    logic        interface_select;
    logic        byte_mode_select;
    logic        byte_order_select;
    logic [2:0]  oversampling_ratio_select;
    logic        standby_n;
    logic        range_select;
    logic        busy;
    logic        first_channel_flag;
    logic [15:0] parallel_output_bus;
    logic        bus_oe_n;
    logic        dout_a;
    logic        dout_b;
    logic        dout_oe_n;

    modport dev (
        input  cs_n, rd_sclk, convert_start_group_a, convert_start_group_b,
        input  interface_select, byte_mode_select, byte_order_select,
        input  oversampling_ratio_select, standby_n, range_select,
        output busy, first_channel_flag, parallel_output_bus, bus_oe_n,
        output dout_a, dout_b, dout_oe_n
    );
    modport host (
        output cs_n, rd_sclk, convert_start_group_a, convert_start_group_b,
        output interface_select, byte_mode_select, byte_order_select,
        output oversampling_ratio_select, standby_n, range_select,
        input  busy, first_channel_flag, parallel_output_bus, bus_oe_n,
        input  dout_a, dout_b, dout_oe_n
    );
endinterface // adcrc_if

// >>> core/adcrc_device.sv
`timescale 1ns/1ns
module adcrc_device #(
    parameter int CONV_CYCLES = adcrc_pkg::CONV_CYC
) (
    // clock and reset
    input  wire logic                                           clk_in,
    input  wire logic                                           nrst_in,
    // link to the host
    adcrc_if.dev                                                link,
    // analog side, one two's complement word per channel
    input  wire logic [adcrc_pkg::NCH-1:0][adcrc_pkg::WBITS-1:0] sample_in,
    // power and filter state
    output logic                                                standby_out,
    output logic                                                shutdown_out,
    output logic                                                wide_bw_out,
    output logic [2:0]                                          ratio_log2_out
);
    import adcrc_pkg::*;

    typedef enum logic {CV_IDLE, CV_RUN} adcrc_cv_t;

    if (CONV_CYCLES < 1 || CONV_CYCLES > 65535) begin : g_chk
        $error("CONV_CYCLES out of range");
    end

    localparam int AW = WBITS + 6;

    logic        cs_q;
    logic        rd_q;
    logic        sa_q;
    logic        sb_q;
    logic        cs_fall;
    logic        strobe_fall;
    logic        sclk_rise;
    logic        a_rise;
    logic        b_rise;
    logic        pd;
    logic        step_end;
    logic        last_step;
    adcrc_mode_t mode;
    adcrc_cv_t   cv_q;
    logic [1:0]  grp_q;
    logic [2:0]  ratio_code_q;
    logic [2:0]  sh_q;
    logic [6:0]  step_q;
    logic [15:0] tmr_q;
    logic signed [AW-1:0] acc_q [NCH];
    logic signed [AW-1:0] sum   [NCH];
    logic [WBITS-1:0] hold_q [NCH];
    logic [WBITS-1:0] res_q  [NCH];
    logic [3:0]  idx_q;
    logic [3:0]  eff;
    logic [2:0]  rch;
    logic        take_msb;
    logic [WBITS-1:0] word;
    logic [6:0]  bit_q;
    logic [6:0]  sbit;
    logic [15:0] bus_q;
    logic        flag_q;
    logic        bus_oe_n_q;
    logic        dout_a_q;
    logic        dout_b_q;
    logic        dout_oe_n_q;

    // pins are synchronous, one stage of history is enough for edges
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            cs_q <= 1'b1;
            rd_q <= 1'b1;
            sa_q <= 1'b0;
            sb_q <= 1'b0;
        end else begin
            cs_q <= link.cs_n;
            rd_q <= link.rd_sclk;
            sa_q <= link.convert_start_group_a;
            sb_q <= link.convert_start_group_b;
        end
    end

    assign mode        = adcrc_mode_f(link.interface_select, link.byte_mode_select);
    assign cs_fall     = cs_q & ~link.cs_n;
    // combined strobe so tied select and read also count as a read edge
    assign strobe_fall = (mode != ADCRC_SER) & (cs_q | rd_q)
                         & ~(link.cs_n | link.rd_sclk);
    assign sclk_rise   = (mode == ADCRC_SER) & ~link.cs_n & ~rd_q & link.rd_sclk;
    assign a_rise      = ~sa_q & link.convert_start_group_a & ~pd;
    assign b_rise      = ~sb_q & link.convert_start_group_b & ~pd;
    assign pd          = ~link.standby_n;

    // power-down state
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            standby_out  <= 1'b0;
            shutdown_out <= 1'b0;
        end else begin
            standby_out  <= pd & link.range_select;
            shutdown_out <= pd & ~link.range_select;
        end
    end

    assign step_end  = (cv_q == CV_RUN) & (tmr_q == 16'h0000);
    assign last_step = step_end & (step_q == 7'((1 << sh_q) - 1));

    // conversion sequencer; either power-down abandons a conversion
    always_ff @(posedge clk_in) begin
        if (!nrst_in || pd) begin
            cv_q   <= CV_IDLE;
            grp_q  <= 2'h0;
            sh_q   <= 3'h0;
            step_q <= 7'h00;
            tmr_q  <= 16'h0000;
        end else begin
            unique case (cv_q)
                CV_IDLE: begin
                    if (a_rise | b_rise) begin
                        cv_q   <= CV_RUN;
                        grp_q  <= {b_rise, a_rise};
                        // only a joint start may average
                        sh_q   <= (a_rise & b_rise) ? adcrc_ratio_shift_f(ratio_code_q)
                                                    : 3'h0;
                        step_q <= 7'h00;
                        tmr_q  <= 16'(CONV_CYCLES - 1);
                    end
                end
                CV_RUN: begin
                    grp_q <= grp_q | {b_rise, a_rise};
                    if (last_step) begin
                        cv_q <= CV_IDLE;
                    end else if (step_end) begin
                        step_q <= step_q + 7'h01;
                        tmr_q  <= 16'(CONV_CYCLES - 1);
                    end else begin
                        tmr_q <= tmr_q - 16'h0001;
                    end
                end
            endcase
        end
    end

    // ratio pins take effect for the conversion after busy falls
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            ratio_code_q   <= 3'h0;
            wide_bw_out    <= 1'b0;
            ratio_log2_out <= 3'h0;
        end else if (last_step) begin
            ratio_code_q   <= link.oversampling_ratio_select;
            wide_bw_out    <= link.oversampling_ratio_select == RATIO_WIDE;
            ratio_log2_out <= adcrc_ratio_shift_f(link.oversampling_ratio_select);
        end
    end

    // track-and-hold per group at its own start edge
    always_ff @(posedge clk_in) begin
        for (int c = 0; c < NCH; c++) begin
            if ((c < NCH / 2) ? a_rise : b_rise)
                hold_q[c] <= sample_in[c];
        end
    end

    // first step converts the held value, later steps resample
    always_comb begin
        for (int c = 0; c < NCH; c++)
            sum[c] = acc_q[c] + AW'(signed'((step_q == 7'h00) ? hold_q[c] : sample_in[c]));
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            for (int c = 0; c < NCH; c++) begin
                acc_q[c] <= '0;
                res_q[c] <= '0;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (last_step) begin
                    acc_q[c] <= '0;
                    if (grp_q[c / (NCH / 2)])
                        res_q[c] <= WBITS'(sum[c] >>> sh_q);
                end else if (step_end) begin
                    acc_q[c] <= sum[c];
                end else if (cv_q == CV_IDLE) begin
                    acc_q[c] <= '0;
                end
            end
        end
    end

    // parallel and byte readout
    assign eff      = cs_fall ? 4'h0 : idx_q;
    assign rch      = (mode == ADCRC_BYTE) ? eff[3:1] : eff[2:0];
    assign word     = res_q[rch];
    assign take_msb = (eff[0] == 1'b0) == link.byte_order_select;

    always_ff @(posedge clk_in) begin
        if (!nrst_in)
            idx_q <= 4'h0;
        else if (strobe_fall && mode == ADCRC_BYTE)
            idx_q <= eff + 4'h1;
        else if (strobe_fall)
            idx_q <= {1'b0, eff[2:0] + 3'h1};
        else if (cs_fall)
            idx_q <= 4'h0;
    end

    // serial readout: channel 1 first on one line, channel 5 on the other
    assign sbit = cs_fall ? 7'h00 : bit_q + 7'h01;

    always_ff @(posedge clk_in) begin
        if (!nrst_in)
            bit_q <= 7'h00;
        else if (cs_fall || sclk_rise)
            bit_q <= sbit;
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            bus_q    <= 16'h0000;
            flag_q   <= 1'b0;
            dout_a_q <= 1'b0;
            dout_b_q <= 1'b0;
        end else if (strobe_fall) begin
            bus_q  <= (mode == ADCRC_BYTE)
                      ? {8'h00, take_msb ? word[15:8] : word[7:0]}
                      : word;
            flag_q <= rch == 3'h0;
        end else if (mode == ADCRC_SER && (cs_fall || sclk_rise)) begin
            dout_a_q <= res_q[sbit[6:4]][~sbit[3:0]];
            dout_b_q <= res_q[sbit[6:4] ^ 3'h4][~sbit[3:0]];
            flag_q   <= sbit[6:4] == 3'h0;
        end
    end

    // enables follow the pins one clock later, aligned with the data
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            bus_oe_n_q  <= 1'b1;
            dout_oe_n_q <= 1'b1;
        end else begin
            bus_oe_n_q  <= ~((mode != ADCRC_SER) & ~link.cs_n & ~link.rd_sclk);
            dout_oe_n_q <= ~((mode == ADCRC_SER) & ~link.cs_n);
        end
    end

    assign link.busy                = cv_q == CV_RUN;
    assign link.first_channel_flag  = flag_q;
    assign link.parallel_output_bus = bus_q;
    assign link.bus_oe_n            = bus_oe_n_q;
    assign link.dout_a              = dout_a_q;
    assign link.dout_b              = dout_b_q;
    assign link.dout_oe_n           = dout_oe_n_q;
endmodule // adcrc_device

// >>> core/adcrc_host.sv
`timescale 1ns/1ns
module adcrc_host #(
    parameter int STROBE_CYCLES = adcrc_pkg::HOST_STROBE_CYC
) (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // link to the converter
    adcrc_if.host            link
);
    import adcrc_pkg::*;

    typedef enum logic [2:0] {RF_IDLE, RF_CS, RF_LO, RF_HI, RF_END} adcrc_rf_t;

    // data is sampled STROBE_CYCLES edges after the strobe falls, so two at the least
    if (STROBE_CYCLES < 2 || STROBE_CYCLES > 255) begin : g_chk
        $error("STROBE_CYCLES out of range");
    end

    adcrc_rf_t        rf_q;
    adcrc_mode_t      mode;
    logic [8:0]       cfg_q;
    logic [7:0]       pcnt_q;
    logic             sa_q;
    logic             sb_q;
    logic             cs_n_q;
    logic             rd_q;
    logic [7:0]       tm_q;
    logic [6:0]       unit_q;
    logic [6:0]       last_unit;
    logic [7:0]       lowb_q;
    logic [15:0]      shf_q;
    logic             ferr_q;
    logic             rack_q;
    logic [15:0]      data_q [NCH];
    logic             ctrl_wr;
    logic             wr_ok;
    logic             smp;
    logic             wdone;
    logic [2:0]       wch;
    logic [15:0]      wval;
    logic             st_a;
    logic             st_b;

    assign mode    = adcrc_mode_f(cfg_q[CFG_IFS], cfg_q[CFG_BYS]);
    assign ctrl_wr = avs_write & (avs_address == REG_CTRL);
    // a new order waits until the previous pulse and frame are over;
    // starts still high at count zero, a new start then would show no edge
    assign avs_waitrequest = (avs_read & ~rack_q)
                             | (ctrl_wr & ((rf_q != RF_IDLE) | (pcnt_q != 8'h00)
                                           | sa_q | sb_q));
    assign wr_ok   = avs_write & ~avs_waitrequest;
    assign st_a    = avs_writedata[CTRL_SA] | (~cfg_q[CFG_SPL] & avs_writedata[CTRL_SB]);
    assign st_b    = avs_writedata[CTRL_SB] | (~cfg_q[CFG_SPL] & avs_writedata[CTRL_SA]);

    always_ff @(posedge clk_in) begin
        if (!nrst_in)
            cfg_q <= CFG_RST;
        else if (wr_ok && avs_address == REG_CFG)
            cfg_q <= avs_writedata[8:0];
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            rack_q       <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            rack_q       <= avs_read & ~rack_q;
            avs_readdata <= 32'h0000_0000;
            if (avs_address >= REG_DATA)
                avs_readdata[15:0] <= data_q[avs_address[2:0]];
            else if (avs_address == REG_CFG)
                avs_readdata[8:0] <= cfg_q;
            else if (avs_address == REG_STAT) begin
                avs_readdata[STAT_BUSY]  <= link.busy;
                avs_readdata[STAT_FRAME] <= rf_q != RF_IDLE;
                avs_readdata[STAT_FERR]  <= ferr_q;
                avs_readdata[STAT_FLAG]  <= link.first_channel_flag;
                avs_readdata[STAT_PULSE] <= pcnt_q != 8'h00;
            end
        end
    end

    // start pulses, joined unless split groups are configured
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            sa_q   <= 1'b0;
            sb_q   <= 1'b0;
            pcnt_q <= 8'h00;
        end else if (wr_ok && ctrl_wr && (st_a || st_b)) begin
            sa_q   <= st_a;
            sb_q   <= st_b;
            pcnt_q <= 8'(STROBE_CYCLES);
        end else if (pcnt_q != 8'h00) begin
            pcnt_q <= pcnt_q - 8'h01;
        end else begin
            sa_q <= 1'b0;
            sb_q <= 1'b0;
        end
    end

    always_comb begin
        unique case (mode)
            ADCRC_PAR:  last_unit = 7'h07;
            ADCRC_BYTE: last_unit = 7'h0f;
            ADCRC_SER:  last_unit = 7'h7f;
            default:    last_unit = 7'h07;
        endcase
    end

    assign smp = (rf_q == RF_LO) & (tm_q == 8'h00);

    always_comb begin
        wdone = 1'b1;
        wch   = unit_q[2:0];
        wval  = link.parallel_output_bus;
        if (mode == ADCRC_BYTE) begin
            wdone = unit_q[0];
            wch   = unit_q[3:1];
            wval  = cfg_q[CFG_ORD] ? {lowb_q, link.parallel_output_bus[7:0]}
                                   : {link.parallel_output_bus[7:0], lowb_q};
        end else if (mode == ADCRC_SER) begin
            wdone = unit_q[3:0] == 4'hf;
            wch   = unit_q[6:4];
            wval  = {shf_q[14:0], link.dout_a};
        end
    end

    // read frame: select low, then strobe low, sample, strobe high
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            rf_q   <= RF_IDLE;
            cs_n_q <= 1'b1;
            rd_q   <= 1'b1;
            tm_q   <= 8'h00;
            unit_q <= 7'h00;
            ferr_q <= 1'b0;
        end else begin
            unique case (rf_q)
                RF_IDLE: begin
                    if (wr_ok && ctrl_wr && avs_writedata[CTRL_RD]) begin
                        rf_q   <= RF_CS;
                        cs_n_q <= 1'b0;
                        tm_q   <= 8'(STROBE_CYCLES - 1);
                        unit_q <= 7'h00;
                        ferr_q <= 1'b0;
                    end
                end
                RF_CS, RF_HI: begin
                    if (tm_q == 8'h00) begin
                        rf_q <= RF_LO;
                        rd_q <= 1'b0;
                        tm_q <= 8'(STROBE_CYCLES - 1);
                    end else begin
                        tm_q <= tm_q - 8'h01;
                    end
                end
                RF_LO: begin
                    if (smp) begin
                        rd_q   <= 1'b1;
                        tm_q   <= 8'(STROBE_CYCLES - 1);
                        unit_q <= unit_q + 7'h01;
                        if (unit_q == 7'h00 && !link.first_channel_flag)
                            ferr_q <= 1'b1;
                        if (unit_q == last_unit) begin
                            rf_q   <= RF_END;
                            cs_n_q <= 1'b1;
                        end else begin
                            rf_q <= RF_HI;
                        end
                    end else begin
                        tm_q <= tm_q - 8'h01;
                    end
                end
                RF_END: begin
                    if (tm_q == 8'h00)
                        rf_q <= RF_IDLE;
                    else
                        tm_q <= tm_q - 8'h01;
                end
                default: rf_q <= RF_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            lowb_q <= 8'h00;
            shf_q  <= 16'h0000;
            for (int c = 0; c < NCH; c++)
                data_q[c] <= 16'h0000;
        end else if (smp) begin
            lowb_q <= link.parallel_output_bus[7:0];
            shf_q  <= wval;
            if (wdone)
                data_q[wch] <= wval;
        end
    end

    assign link.cs_n                      = cs_n_q;
    assign link.rd_sclk                   = rd_q;
    assign link.convert_start_group_a     = sa_q;
    assign link.convert_start_group_b     = sb_q;
    assign link.interface_select          = cfg_q[CFG_IFS];
    assign link.byte_mode_select          = cfg_q[CFG_BYS];
    assign link.byte_order_select         = cfg_q[CFG_ORD];
    // split starts forbid averaging, so the ratio pins read zero then
    assign link.oversampling_ratio_select = cfg_q[CFG_SPL] ? 3'h0 : cfg_q[CFG_RATIO +: 3];
    assign link.standby_n                 = cfg_q[CFG_SBY];
    assign link.range_select              = cfg_q[CFG_RNG];
endmodule // adcrc_host

// >>> tb/adcrc_checker.sv
`timescale 1ns/1ns
module adcrc_checker (
    // clock and reset
    input wire logic        clk_in,
    input wire logic        nrst_in,
    // link signals
    input wire logic        cs_n,
    input wire logic        rd_sclk,
    input wire logic        convert_start_group_a,
    input wire logic        interface_select,
    input wire logic        byte_mode_select,
    input wire logic        standby_n,
    input wire logic        busy,
    input wire logic        first_channel_flag,
    input wire logic [15:0] parallel_output_bus,
    input wire logic        bus_oe_n,
    input wire logic        dout_oe_n
);
    logic [4:0] rd_cnt_q;
    logic       par;
    logic       byt;
    assign par = !interface_select;
    assign byt = interface_select && byte_mode_select;
    // strobes seen since the frame opened
    always_ff @(posedge clk_in) begin
        if (!nrst_in || cs_n)
            rd_cnt_q <= 5'h0;
        else if ($fell(rd_sclk))
            rd_cnt_q <= rd_cnt_q + 5'h1;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    oe_needs_sel_a: assert property (!bus_oe_n |-> $past(!cs_n && !rd_sclk))
        else $error("bus driven without select and read");
    oe_follows_a: assert property ((par || byt) && standby_n && !cs_n && !rd_sclk |=> !bus_oe_n)
        else $error("bus not driven during read");
    float_a: assert property ($rose(cs_n) || $rose(rd_sclk) |=> bus_oe_n)
        else $error("bus still driven after release");
    par_flag_a: assert property (par && !bus_oe_n |-> first_channel_flag == (rd_cnt_q == 5'h1))
        else $error("flag wrong in parallel frame");
    byte_flag_a: assert property (byt && !bus_oe_n |-> first_channel_flag == (rd_cnt_q <= 5'h2))
        else $error("flag wrong in byte frame");
    byte_lane_a: assert property (byt && !bus_oe_n |-> parallel_output_bus[15:8] == 8'h00)
        else $error("upper lanes used in byte mode");
    serial_quiet_a: assert property (interface_select && !byte_mode_select |-> bus_oe_n)
        else $error("parallel bus driven in serial mode");
    serial_oe_a: assert property (interface_select && !byte_mode_select && !cs_n
        |=> !dout_oe_n)
        else $error("serial lines not driven in frame");
    dout_float_a: assert property ($rose(cs_n) |=> dout_oe_n)
        else $error("serial lines still driven after release");
    start_busy_a: assert property ($rose(convert_start_group_a) && standby_n && !busy
        |-> ##[1:2] busy)
        else $error("start did not raise busy");
    busy_min_a: assert property ($rose(busy) |-> busy [*4])
        else $error("conversion shorter than one step");
    cover property ($fell(busy));
    cover property (byt && !bus_oe_n);
    cover property (par && first_channel_flag && !bus_oe_n);
endmodule // adcrc_checker

// >>> tb/testbench.sv
`timescale 1ns/1ns
module testbench;
    import adcrc_pkg::*;
    logic             clk_in = 1'b0;
    logic             nrst_in = 1'b0;
    logic [3:0]       avs_address = 4'h0;
    logic             avs_read = 1'b0;
    logic             avs_write = 1'b0;
    logic [31:0]      avs_writedata = 32'h0000_0000;
    logic [31:0]      avs_readdata;
    logic             avs_waitrequest;
    logic [7:0][15:0] smp = '0;
    logic [7:0][15:0] old;
    logic             sby, sdn, wide;
    logic [2:0]       rlog;
    logic [31:0]      q;
    int               n_mismatch = 0;
    int               total_checks = 0;
    localparam logic [31:0] MCFG [4] = '{32'h0000_00c0, 32'h0000_00c7, 32'h0000_00c3,
                                         32'h0000_00c1};
    adcrc_if i_adcrc_if ();
    adcrc_host i_adcrc_host (.clk_in(clk_in), .nrst_in(nrst_in), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(i_adcrc_if));
    adcrc_device #(.CONV_CYCLES(4)) i_adcrc_device (.clk_in(clk_in), .nrst_in(nrst_in),
        .link(i_adcrc_if), .sample_in(smp), .standby_out(sby), .shutdown_out(sdn),
        .wide_bw_out(wide), .ratio_log2_out(rlog));
    adcrc_checker i_adcrc_checker (.clk_in(clk_in), .nrst_in(nrst_in), .cs_n(i_adcrc_if.cs_n),
        .rd_sclk(i_adcrc_if.rd_sclk), .convert_start_group_a(i_adcrc_if.convert_start_group_a),
        .interface_select(i_adcrc_if.interface_select), .standby_n(i_adcrc_if.standby_n),
        .byte_mode_select(i_adcrc_if.byte_mode_select), .busy(i_adcrc_if.busy),
        .first_channel_flag(i_adcrc_if.first_channel_flag), .bus_oe_n(i_adcrc_if.bus_oe_n),
        .parallel_output_bus(i_adcrc_if.parallel_output_bus),
        .dout_oe_n(i_adcrc_if.dout_oe_n));
    initial forever #10 clk_in = ~clk_in;
    function automatic logic [31:0] ratio_f(input int k);
        return (k == 7) ? 32'h0 : 32'(k);
    endfunction
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // request held until an edge sees waitrequest low; data taken there
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do
            @(posedge clk_in);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wait_st(input logic [31:0] m);
        int n;
        n = 0;
        do begin
            bus(1'b0, REG_STAT, 32'h0);
            n++;
        end while ((q & m) != 0 && n < 500);
        if (n >= 500)
            n_mismatch++;
    endtask
    task automatic conv(input logic [31:0] cfg);
        bus(1'b1, REG_CFG, cfg);
        bus(1'b1, REG_CTRL, 32'h0000_0001);
        wait_st(32'h0000_0013);
    endtask
    task automatic frame(input logic [7:0][15:0] e);
        bus(1'b1, REG_CTRL, 32'h0000_0004);
        wait_st(32'h0000_0012);
        chk("ferr", q[STAT_FERR], 1'b0);
        for (int c = 0; c < NCH; c++) begin
            bus(1'b0, REG_DATA + 4'(c), 32'h0);
            chk("data", q[15:0], e[c]);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (50000) @(posedge clk_in);
        n_mismatch++;
        final_report;
    end
    initial begin
        void'($urandom(32'ha00b));
        repeat (3) @(posedge clk_in);
        nrst_in <= 1'b1;
        bus(1'b0, REG_CFG, 32'h0);
        chk("cfg", q[8:0], CFG_RST);
        bus(1'b0, 4'h5, 32'h0);
        chk("unmapped", q, 32'h0);
        for (int k = 0; k < 8; k++) begin
            conv(32'h0000_00c0 | (k << 3));
            chk("ratio", rlog, ratio_f(k));
            chk("wide", wide, k == 7);
        end
        // every readout mode, fresh samples each time
        foreach (MCFG[m]) begin
            for (int c = 0; c < NCH; c++)
                smp[c] <= 16'($urandom);
            conv(MCFG[m]);
            frame(smp);
        end
        // long averaged conversion so the next frame lands inside busy
        conv(32'h0000_00f0);
        old = smp;
        for (int c = 0; c < NCH; c++)
            smp[c] <= 16'($urandom);
        bus(1'b1, REG_CTRL, 32'h0000_0001);
        frame(old);
        bus(1'b0, REG_STAT, 32'h0);
        chk("busy", q[0], 1'b1);
        wait_st(32'h0000_0013);
        frame(smp);
        // split groups: A alone converts once, ratio pins ignored
        bus(1'b1, REG_CFG, 32'h0000_01f0);
        old = smp;
        for (int c = 0; c < NCH / 2; c++)
            old[c] = 16'($urandom);
        smp <= old;
        bus(1'b1, REG_CTRL, 32'h0000_0001);
        repeat (2) @(posedge clk_in);
        // later samples differ, so any averaging would show
        smp <= ~old;
        wait_st(32'h0000_0013);
        frame(old);
        chk("ratio", rlog, 32'h0);
        bus(1'b1, REG_CFG, 32'h0000_0080);
        repeat (3) @(posedge clk_in);
        chk("standby", {sby, sdn}, 2'b10);
        bus(1'b1, REG_CFG, 32'h0000_0000);
        repeat (3) @(posedge clk_in);
        chk("shutdown", {sby, sdn}, 2'b01);
        final_report;
    end
endmodule // testbench
